// ---- common/elc_params.svh ----
// Constants for the enclave lifecycle control block
`ifndef ELC_PARAMS_SVH
`define ELC_PARAMS_SVH
`define ELC_ATTR_INIT_BIT      0
`define ELC_ATTR_DEBUG_BIT     1
`define ELC_ATTR_TOKENKEY_BIT  5
`define ELC_FC_LOCK_BIT        0
`define ELC_FC_LEKEY_WR_BIT    17
`define ELC_CAP_LC_BIT         0
`define ELC_HASH_WORDS         4
`define ELC_LE_HASH_RST        64'h5A5A_0F0F_C3C3_9696
`define ELC_GPR_LEGACY_LAST    5'h07
`define ELC_GPR_RIP            5'h10
`define ELC_GPR_LAST           5'h11
`define ELC_XCR_RST            64'h0000_0000_0000_0001
`define ELC_ZERO64             64'h0000_0000_0000_0000
`endif

// ---- common/elc_pkg.sv ----
// Types shared by the enclave lifecycle control block
package elc_pkg;
  typedef enum logic [3:0] {
    ELC_OP_NONE   = 4'h0,
    ELC_OP_CREATE = 4'h1,
    ELC_OP_PGADD  = 4'h2,
    ELC_OP_MEXT   = 4'h3,
    ELC_OP_INIT   = 4'h4,
    ELC_OP_ENTER  = 4'h5,
    ELC_OP_EXIT   = 4'h6,
    ELC_OP_RESUME = 4'h7,
    ELC_OP_KEYDRV = 4'h8
  } elc_op_t;

  typedef enum logic [2:0] {
    ELC_ERR_NONE    = 3'h0,
    ELC_ERR_SIG     = 3'h1,
    ELC_ERR_MEAS    = 3'h2,
    ELC_ERR_ATTR    = 3'h3,
    ELC_ERR_TOKEN   = 3'h4,
    ELC_ERR_BUSY    = 3'h5,
    ELC_ERR_NOTINIT = 3'h6,
    ELC_ERR_STATE   = 3'h7
  } elc_err_t;

  typedef enum logic [11:0] {
    ELC_ST_IDLE      = 12'h001,
    ELC_ST_INIT_SIG  = 12'h002,
    ELC_ST_INIT_MEAS = 12'h004,
    ELC_ST_INIT_ATTR = 12'h008,
    ELC_ST_INIT_FIN  = 12'h010,
    ELC_ST_ENT_CHK   = 12'h020,
    ELC_ST_ENT_SETUP = 12'h040,
    ELC_ST_ENT_GO    = 12'h080,
    ELC_ST_RES_GPR   = 12'h100,
    ELC_ST_RES_XF    = 12'h200,
    ELC_ST_AEX_SAVE  = 12'h400,
    ELC_ST_AEX_SYN   = 12'h800
  } elc_state_t;
endpackage : elc_pkg

// ---- core/elc_key_hash_regs.sv ----
// Launch key hash register set with lock-gated write access
`timescale 1ns/100ps
`include "elc_params.svh"
module elc_key_hash_regs
  import elc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [63:0]  capability,
  input  wire logic [63:0]  featureControl,
  input  wire logic         hashWrEn,
  input  wire logic [1:0]   hashWrIdx,
  input  wire logic [63:0]  hashWrData,
  output logic              hashWrRefused,
  output logic              hashWritable,
  output logic [255:0]      launchKeyHash
);
  typedef struct packed {
    logic [`ELC_HASH_WORDS-1:0][63:0] words;
    logic                             refused;
  } elc_khr_t;

  elc_khr_t cur;
  elc_khr_t next_cur;

  // Writable only with capability present and feature control locked with its enable bit
  assign hashWritable = capability[`ELC_CAP_LC_BIT] & featureControl[`ELC_FC_LOCK_BIT]
                      & featureControl[`ELC_FC_LEKEY_WR_BIT];

  // Refused writes leave the digest unchanged and pulse a flag
  always_comb begin
    next_cur = cur;
    next_cur.refused = 1'b0;
    if (hashWrEn) begin
      if (hashWritable) begin
        next_cur.words[hashWrIdx] = hashWrData;
      end else begin
        next_cur.refused = 1'b1;
      end
    end
  end

  // Reset reloads the default launch signer digest
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur.words   <= {`ELC_HASH_WORDS{`ELC_LE_HASH_RST}};
      cur.refused <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign hashWrRefused = cur.refused;
  assign launchKeyHash = cur.words;
endmodule : elc_key_hash_regs

// ---- core/elc_lifecycle_ctrl.sv ----
// Enclave lifecycle control: initialization, launch gating, entry, exit, async exit, resume
`timescale 1ns/100ps
`include "elc_params.svh"
module elc_lifecycle_ctrl
  import elc_pkg::*;
#(
  parameter int TCS_COUNT = 4,
  parameter int TCS_IDX_W = 2
)(
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Leaf request and answer
  input  wire logic                 leafValid,
  input  wire elc_op_t              leafOp,
  output logic                      leafReady,
  output logic                      leafDone,
  output logic                      leafFault,
  output elc_err_t                  leafErr,
  // Initialization inputs
  input  wire logic                 sigVerified,
  input  wire logic [255:0]         measurement,
  input  wire logic [255:0]         expectedMeasurement,
  input  wire logic                 attrCompatible,
  input  wire logic                 tokenValid,
  input  wire logic [255:0]         signerKeyHash,
  input  wire logic [15:0]          productIdent,
  input  wire logic [15:0]          securityVersionNum,
  input  wire logic [63:0]          enclaveAttributes,
  input  wire logic [63:0]          featureRequestMask,
  output logic [255:0]              enclaveIdentity,
  output logic [255:0]              sealingAuthority,
  output logic [15:0]               sealProductIdent,
  output logic [15:0]               sealSecurityVersion,
  output logic                      initialized,
  output logic                      keyDeriveGrant,
  // Launch key hash access
  input  wire logic [63:0]          capability,
  input  wire logic [63:0]          featureControl,
  input  wire logic                 hashWrEn,
  input  wire logic [1:0]           hashWrIdx,
  input  wire logic [63:0]          hashWrData,
  output logic                      hashWrRefused,
  output logic                      hashWritable,
  output logic [255:0]              launchKeyHash,
  // Entry and exit
  input  wire logic [TCS_IDX_W-1:0] threadStructIdx,
  input  wire logic                 threadStructOwned,
  input  wire logic [63:0]          threadEntryAddr,
  input  wire logic [63:0]          asyncExitReturnAddr,
  input  wire logic [63:0]          exitTarget,
  input  wire logic [63:0]          stackPtrIn,
  input  wire logic [63:0]          framePtrIn,
  input  wire logic [63:0]          extendedControlIn,
  input  wire logic                 debugRequest,
  output logic                      enclaveMode,
  output logic [TCS_COUNT-1:0]      threadBusy,
  output logic                      flushTranslations,
  output logic [63:0]               savedStackPtr,
  output logic [63:0]               savedFramePtr,
  output logic [63:0]               savedExtendedControl,
  output logic [63:0]               extendedControl,
  output logic                      singleInstruction,
  output logic                      debugTrapsAllowed,
  output logic                      jumpValid,
  output logic [63:0]               jumpAddr,
  output logic [63:0]               returnedExitAddr,
  // Exiting events
  input  wire logic                 exitingEvent,
  output logic                      saveFrame,
  output logic                      loadSynthetic,
  output logic                      eventAddrPush,
  output logic [63:0]               eventAddr,
  output logic                      outsideEvent,
  // Resume
  input  wire logic                 longModeActive,
  input  wire logic                 codeSegLong,
  input  wire logic [63:0]          frameRdData,
  output logic [4:0]                frameRdIdx,
  output logic                      gprWrEn,
  output logic [4:0]                gprWrIdx,
  output logic [63:0]               gprWrMask,
  output logic [63:0]               gprWrData,
  output logic                      xfeatRestore,
  output logic [63:0]               xfeatRestoreMask,
  output logic                      fpLayout64
);
  typedef struct packed {
    elc_state_t                 st;
    logic                       resume;
    logic                       inited;
    logic                       tokenKeyAttr;
    logic                       debuggable;
    logic [63:0]                featMask;
    logic [TCS_COUNT-1:0]       busy;
    logic [TCS_IDX_W-1:0]       curTcs;
    logic [63:0]                async_exit_return_addr;
    logic                       mode;
    logic [63:0]                sp;
    logic [63:0]                bp;
    logic [63:0]                xcrSaved;
    logic [63:0]                xcr;
    logic                       single;
    logic                       traps;
    logic                       jump;
    logic [63:0]                jAddr;
    logic                       flush;
    logic                       done;
    logic                       fault;
    elc_err_t                   err;
    logic                       grant;
    logic [63:0]                aepOut;
    logic [255:0]               encId;
    logic [255:0]               signer;
    logic [15:0]                prod;
    logic [15:0]                svn;
    logic [4:0]                 rIdx;
    logic                       gWr;
    logic [4:0]                 gIdx;
    logic [63:0]                gMask;
    logic [63:0]                gData;
    logic                       xfRest;
    logic                       fp64;
    logic                       save;
    logic                       synth;
    logic                       push;
    logic                       outside;
  } elc_ctl_t;

  elc_ctl_t    cur;
  elc_ctl_t    next_cur;
  logic        resLoadEn;
  logic [63:0] resLoadMask;
  logic [63:0] resLoadValue;
  logic        launchEnclave;

  elc_key_hash_regs u_hash (
    .clk            (clk),
    .rst            (rst),
    .capability     (capability),
    .featureControl (featureControl),
    .hashWrEn       (hashWrEn),
    .hashWrIdx      (hashWrIdx),
    .hashWrData     (hashWrData),
    .hashWrRefused  (hashWrRefused),
    .hashWritable   (hashWritable),
    .launchKeyHash  (launchKeyHash)
  );

  elc_resume_restore u_restore (
    .gprIdx         (cur.rIdx),
    .savedValue     (frameRdData),
    .longModeActive (longModeActive),
    .codeSegLong    (codeSegLong),
    .loadEn         (resLoadEn),
    .loadMask       (resLoadMask),
    .loadValue      (resLoadValue)
  );

  // Signer matching the hash registers marks a launch enclave
  assign launchEnclave = (signerKeyHash == launchKeyHash);
  // Exiting events take precedence over new leaf requests
  assign leafReady     = (cur.st == ELC_ST_IDLE) && !exitingEvent;

  // Next-state logic; pulse fields return to zero every cycle
  always_comb begin
    next_cur         = cur;
    next_cur.jump    = 1'b0;
    next_cur.flush   = 1'b0;
    next_cur.done    = 1'b0;
    next_cur.fault   = 1'b0;
    next_cur.grant   = 1'b0;
    next_cur.gWr     = 1'b0;
    next_cur.xfRest  = 1'b0;
    next_cur.save    = 1'b0;
    next_cur.synth   = 1'b0;
    next_cur.push    = 1'b0;
    next_cur.outside = 1'b0;
    unique case (cur.st)
      ELC_ST_IDLE: begin
        next_cur.err = ELC_ERR_NONE;
        if (exitingEvent && cur.mode) begin
          next_cur.st = ELC_ST_AEX_SAVE;
        end else if (exitingEvent) begin
          next_cur.outside = 1'b1;
        end else if (leafValid) begin
          next_cur.done = 1'b1;
          unique case (leafOp)
            ELC_OP_CREATE: begin
              next_cur.inited = 1'b0;
            end
            ELC_OP_PGADD, ELC_OP_MEXT: begin
              if (cur.inited) begin
                next_cur.fault = 1'b1;
                next_cur.err   = ELC_ERR_STATE;
              end
            end
            ELC_OP_INIT: begin
              next_cur.done = 1'b0;
              next_cur.st   = ELC_ST_INIT_SIG;
            end
            ELC_OP_ENTER, ELC_OP_RESUME: begin
              next_cur.done   = 1'b0;
              next_cur.curTcs = threadStructIdx;
              next_cur.resume = (leafOp == ELC_OP_RESUME);
              next_cur.st     = ELC_ST_ENT_CHK;
            end
            ELC_OP_EXIT: begin
              if (!cur.mode) begin
                next_cur.fault = 1'b1;
                next_cur.err   = ELC_ERR_STATE;
              end else begin
                next_cur.mode               = 1'b0;
                next_cur.flush              = 1'b1;
                next_cur.busy[cur.curTcs]   = 1'b0;
                next_cur.xcr                = cur.xcrSaved;
                next_cur.jump               = 1'b1;
                next_cur.jAddr              = exitTarget;
                next_cur.aepOut             = cur.async_exit_return_addr;
              end
            end
            ELC_OP_KEYDRV: begin
              next_cur.grant = cur.inited && cur.tokenKeyAttr;
              next_cur.fault = !(cur.inited && cur.tokenKeyAttr);
            end
            default: begin
              next_cur.fault = 1'b1;
              next_cur.err   = ELC_ERR_STATE;
            end
          endcase
        end
      end
      // Signature, measurement and attribute steps each abort with their own error code
      ELC_ST_INIT_SIG: begin
        if (cur.inited || !sigVerified) begin
          next_cur.st    = ELC_ST_IDLE;
          next_cur.done  = 1'b1;
          next_cur.fault = 1'b1;
          next_cur.err   = cur.inited ? ELC_ERR_STATE : ELC_ERR_SIG;
        end else begin
          next_cur.st = ELC_ST_INIT_MEAS;
        end
      end
      ELC_ST_INIT_MEAS: begin
        if (measurement != expectedMeasurement) begin
          next_cur.st    = ELC_ST_IDLE;
          next_cur.done  = 1'b1;
          next_cur.fault = 1'b1;
          next_cur.err   = ELC_ERR_MEAS;
        end else begin
          next_cur.st = ELC_ST_INIT_ATTR;
        end
      end
      ELC_ST_INIT_ATTR: begin
        next_cur.st = ELC_ST_INIT_FIN;
        if (!attrCompatible || !(tokenValid || launchEnclave)) begin
          next_cur.st    = ELC_ST_IDLE;
          next_cur.done  = 1'b1;
          next_cur.fault = 1'b1;
          next_cur.err   = !attrCompatible ? ELC_ERR_ATTR : ELC_ERR_TOKEN;
        end
      end
      // Record identities last so a failed init leaves them untouched
      ELC_ST_INIT_FIN: begin
        next_cur.encId        = measurement;
        next_cur.signer       = signerKeyHash;
        next_cur.prod         = productIdent;
        next_cur.svn          = securityVersionNum;
        next_cur.tokenKeyAttr = enclaveAttributes[`ELC_ATTR_TOKENKEY_BIT];
        next_cur.debuggable   = enclaveAttributes[`ELC_ATTR_DEBUG_BIT];
        next_cur.featMask     = featureRequestMask;
        next_cur.inited       = 1'b1;
        next_cur.done         = 1'b1;
        next_cur.st           = ELC_ST_IDLE;
      end
      // Shared gate for entry and resume
      ELC_ST_ENT_CHK: begin
        if (!cur.inited || cur.busy[cur.curTcs] || cur.mode || !threadStructOwned) begin
          next_cur.st    = ELC_ST_IDLE;
          next_cur.done  = 1'b1;
          next_cur.fault = 1'b1;
          next_cur.err   = !cur.inited ? ELC_ERR_NOTINIT :
                           (cur.busy[cur.curTcs] ? ELC_ERR_BUSY : ELC_ERR_STATE);
        end else begin
          next_cur.flush = 1'b1;
          next_cur.st    = ELC_ST_ENT_SETUP;
        end
      end
      ELC_ST_ENT_SETUP: begin
        next_cur.mode     = 1'b1;
        next_cur.sp       = stackPtrIn;
        next_cur.bp       = framePtrIn;
        next_cur.xcrSaved = extendedControlIn;
        next_cur.xcr      = cur.featMask;
        next_cur.async_exit_return_addr      = asyncExitReturnAddr;
        next_cur.rIdx     = 5'h00;
        next_cur.st       = cur.resume ? ELC_ST_RES_GPR : ELC_ST_ENT_GO;  // Op may change after take
      end
      ELC_ST_ENT_GO: begin
        next_cur.traps            = cur.debuggable && debugRequest;
        next_cur.single           = !(cur.debuggable && debugRequest);
        next_cur.busy[cur.curTcs] = 1'b1;
        next_cur.jump             = 1'b1;
        next_cur.jAddr            = threadEntryAddr;
        next_cur.done             = 1'b1;
        next_cur.st               = ELC_ST_IDLE;
      end
      // One saved register per cycle, masked by mode
      ELC_ST_RES_GPR: begin
        next_cur.gWr   = resLoadEn;
        next_cur.gIdx  = cur.rIdx;
        next_cur.gMask = resLoadMask;
        next_cur.gData = resLoadValue;
        if (cur.rIdx == `ELC_GPR_RIP) begin
          next_cur.jAddr = resLoadValue;
        end
        if (cur.rIdx == `ELC_GPR_LAST) begin
          next_cur.st = ELC_ST_RES_XF;
        end else begin
          next_cur.rIdx = cur.rIdx + 5'h01;
        end
      end
      ELC_ST_RES_XF: begin
        next_cur.xfRest           = 1'b1;
        next_cur.fp64             = longModeActive && codeSegLong;
        next_cur.traps            = cur.debuggable && debugRequest;
        next_cur.single           = !(cur.debuggable && debugRequest);
        next_cur.busy[cur.curTcs] = 1'b1;
        next_cur.jump             = 1'b1;
        next_cur.done             = 1'b1;
        next_cur.st               = ELC_ST_IDLE;
      end
      // State goes to the frame before any synthetic value replaces it
      ELC_ST_AEX_SAVE: begin
        next_cur.save = 1'b1;
        next_cur.st   = ELC_ST_AEX_SYN;
      end
      ELC_ST_AEX_SYN: begin
        next_cur.synth            = 1'b1;
        next_cur.mode             = 1'b0;
        next_cur.busy[cur.curTcs] = 1'b0;
        next_cur.xcr              = cur.xcrSaved;
        next_cur.flush            = 1'b1;
        next_cur.push             = 1'b1;
        next_cur.jAddr            = cur.async_exit_return_addr;
        next_cur.st               = ELC_ST_IDLE;
      end
    endcase
  end

  // Single register of all control state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur          <= '0;
      cur.st       <= ELC_ST_IDLE;
      cur.err      <= ELC_ERR_NONE;
      cur.xcr      <= `ELC_XCR_RST;
      cur.xcrSaved <= `ELC_XCR_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from registered state
  assign leafDone             = cur.done;
  assign leafFault            = cur.fault;
  assign leafErr              = cur.err;
  assign enclaveIdentity      = cur.encId;
  assign sealingAuthority     = cur.signer;
  assign sealProductIdent     = cur.prod;
  assign sealSecurityVersion  = cur.svn;
  assign initialized          = cur.inited;
  assign keyDeriveGrant       = cur.grant;
  assign enclaveMode          = cur.mode;
  assign threadBusy           = cur.busy;
  assign flushTranslations    = cur.flush;
  assign savedStackPtr        = cur.sp;
  assign savedFramePtr        = cur.bp;
  assign savedExtendedControl = cur.xcrSaved;
  assign extendedControl      = cur.xcr;
  assign singleInstruction    = cur.single;
  assign debugTrapsAllowed    = cur.traps;
  assign jumpValid            = cur.jump;
  assign jumpAddr             = cur.jAddr;
  assign returnedExitAddr     = cur.aepOut;
  assign saveFrame            = cur.save;
  assign loadSynthetic        = cur.synth;
  assign eventAddrPush        = cur.push;
  assign eventAddr            = cur.jAddr;
  assign outsideEvent         = cur.outside;
  assign frameRdIdx           = cur.rIdx;
  assign gprWrEn              = cur.gWr;
  assign gprWrIdx             = cur.gIdx;
  assign gprWrMask            = cur.gMask;
  assign gprWrData            = cur.gData;
  assign xfeatRestore         = cur.xfRest;
  assign xfeatRestoreMask     = cur.featMask;
  assign fpLayout64           = cur.fp64;
endmodule : elc_lifecycle_ctrl

// ---- core/elc_resume_restore.sv ----
// Mode-dependent masking of one saved register during resume
`timescale 1ns/100ps
`include "elc_params.svh"
module elc_resume_restore
  import elc_pkg::*;
(
  input  wire logic [4:0]  gprIdx,
  input  wire logic [63:0] savedValue,
  input  wire logic        longModeActive,
  input  wire logic        codeSegLong,
  output logic             loadEn,
  output logic [63:0]      loadMask,
  output logic [63:0]      loadValue
);
  logic wide;
  logic legacy;

  // Legacy registers, instruction pointer and flags load in every mode
  assign wide   = longModeActive & codeSegLong;
  assign legacy = (gprIdx <= `ELC_GPR_LEGACY_LAST) || (gprIdx >= `ELC_GPR_RIP);

  // Narrow mode skips R8..R15 and keeps upper halves untouched
  always_comb begin
    loadEn    = wide | legacy;
    loadMask  = wide ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
    loadValue = savedValue & loadMask;
  end
endmodule : elc_resume_restore

// ---- tb/elc_asserts.sv ----
// Checker on the lifecycle control block ports
`timescale 1ns/100ps
module elc_asserts
  import elc_pkg::*;
(
  input wire logic clk, rst, leafValid, leafReady, leafDone, leafFault, initialized,
  input wire logic keyDeriveGrant, hashWrEn, hashWrRefused, hashWritable, enclaveMode,
  input wire logic flushTranslations, jumpValid, saveFrame, loadSynthetic, eventAddrPush,
  input wire logic gprWrEn, longModeActive, codeSegLong,
  input wire elc_op_t leafOp,
  input wire logic [63:0] capability, featureControl, enclaveAttributes,
  input wire logic [63:0] asyncExitReturnAddr, returnedExitAddr, gprWrMask,
  input wire logic [4:0] gprWrIdx
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Taken exit from inside, taken add or extend
  wire ex = leafValid && leafReady && leafOp == ELC_OP_EXIT && enclaveMode;
  wire ad = leafValid && leafReady && (leafOp == ELC_OP_PGADD || leafOp == ELC_OP_MEXT);
  a_hash_refuse: assert property (hashWrEn && !hashWritable |=> hashWrRefused)
    else $error("hash write not refused");
  a_hash_gate: assert property (hashWritable |-> capability[0] && featureControl[0] &&
    featureControl[17]) else $error("hash writable while unlocked");
  a_exit_flush: assert property (ex |=> flushTranslations && !enclaveMode && jumpValid)
    else $error("exit did not leave cleanly");
  a_exit_addr: assert property (ex |=> returnedExitAddr == $past(asyncExitReturnAddr))
    else $error("exit return address wrong");
  a_add_fault: assert property (ad && initialized |=> leafDone && leafFault)
    else $error("add after init not faulted");
  a_aex_order: assert property (saveFrame |=> loadSynthetic && eventAddrPush && !enclaveMode)
    else $error("async exit order wrong");
  a_narrow_load: assert property (gprWrEn && !(longModeActive && codeSegLong) |->
    gprWrMask == 64'h0000_0000_FFFF_FFFF && !gprWrIdx[3]) else $error("narrow restore wrong");
  a_wide_load: assert property (gprWrEn && longModeActive && codeSegLong |-> &gprWrMask)
    else $error("wide restore not full");
  a_key_grant: assert property (keyDeriveGrant |-> enclaveAttributes[5] && initialized)
    else $error("key granted without attribute");
  a_enter_init: assert property (jumpValid && enclaveMode |-> initialized)
    else $error("entered uninitialized enclave");
endmodule : elc_asserts

// ---- tb/elc_lifecycle_ctrl_tb_top.sv ----
// Random and corner-case bench for the lifecycle control block
`timescale 1ns/100ps
`include "elc_params.svh"
module elc_lifecycle_ctrl_tb_top
  import elc_pkg::*;
;
  logic clk = 0, rst = 1, leafValid = 0, sigVerified = 1, attrCompatible = 1, tokenValid = 0;
  logic hashWrEn = 0, debugRequest, exitingEvent = 0, longModeActive, codeSegLong = 1;
  logic leafReady, leafDone, leafFault, initialized, keyDeriveGrant, hashWrRefused;
  logic hashWritable, threadStructOwned, enclaveMode, flushTranslations, singleInstruction;
  logic debugTrapsAllowed, jumpValid, saveFrame, loadSynthetic, eventAddrPush, outsideEvent;
  logic gprWrEn, xfeatRestore, fpLayout64;
  elc_op_t leafOp = ELC_OP_NONE;
  elc_err_t leafErr;
  logic [255:0] measurement, expectedMeasurement, signerKeyHash, enclaveIdentity, kh;
  logic [255:0] sealingAuthority, launchKeyHash;
  logic [15:0] productIdent, securityVersionNum, sealProductIdent, sealSecurityVersion;
  logic [63:0] enclaveAttributes, featureRequestMask, capability, featureControl, hashWrData;
  logic [63:0] threadEntryAddr, asyncExitReturnAddr, exitTarget, stackPtrIn, framePtrIn;
  logic [63:0] extendedControlIn, savedStackPtr, savedFramePtr, savedExtendedControl;
  logic [63:0] extendedControl, jumpAddr, returnedExitAddr, eventAddr, frameRdData;
  logic [63:0] gprWrMask, gprWrData, xfeatRestoreMask;
  logic [4:0] frameRdIdx, gprWrIdx;
  logic [1:0] threadStructIdx = 0, hashWrIdx;
  logic foreignTcs = 0;
  logic [3:0] threadBusy;
  logic [31:0] seed = 32'h5C44;
  int errors = 0, compares = 0;
  elc_lifecycle_ctrl i_dut (.*);
  elc_sw_model i_sw (.*);
  always #5 clk = ~clk;
  // Galois-free shift register, fixed start for repeatable runs
  function automatic logic [63:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {seed, ~seed};
  endfunction : rnd
  task automatic chk(string n, logic [255:0] e, logic [255:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Bounded wait; a hang counts as a mismatch
  task automatic wt(ref logic s);
    int i;
    for (i = 0; i < 40 && s !== 1'b1; i++) @(posedge clk) #1;
    if (s !== 1'b1) begin
      errors++;
      summarize();
    end
  endtask : wt
  task automatic leaf(elc_op_t op, logic f, elc_err_t e = ELC_ERR_NONE);
    leafOp = op;
    leafValid = 1;
    @(posedge clk) #1 leafValid = 0;
    wt(leafDone);
    chk("leafFault", f, leafFault);
    chk("leafErr", e, leafErr);
    // Idle edge so the next request never re-raises valid in this step
    @(posedge clk) #1;
  endtask : leaf
  initial begin
    {productIdent, securityVersionNum, hashWrIdx, debugRequest, longModeActive} = 36'(rnd());
    {featureRequestMask, threadEntryAddr, exitTarget} = {rnd(), rnd(), rnd()};
    {stackPtrIn, framePtrIn, extendedControlIn} = {rnd(), rnd(), rnd()};
    measurement = {4{rnd()}};
    expectedMeasurement = measurement;
    enclaveAttributes = 64'h0000_0000_0000_0022; // Token-key and debuggable
    capability = 64'h0000_0000_0000_0001;
    signerKeyHash = '0;
    kh = {4{`ELC_LE_HASH_RST}};
    repeat (8) @(posedge clk);
    #1 rst = 0;
    chk("launchKeyHash", kh, launchKeyHash);
    for (int k = 0; k < 4; k++) begin
      featureControl = {46'h0, k[1], 16'h0, k[0]};
      {hashWrIdx, hashWrData} = {2'(rnd()), rnd()};
      if (k == 3) kh[64*hashWrIdx+:64] = hashWrData;
      hashWrEn = 1;
      @(posedge clk) #1 hashWrEn = 0;
      chk("hashWrRefused", k != 3, hashWrRefused);
      chk("launchKeyHash", kh, launchKeyHash);
      @(posedge clk) #1;
    end
    $display("test hash done");
    leaf(ELC_OP_CREATE, 0);
    leaf(ELC_OP_ENTER, 1, ELC_ERR_NOTINIT);
    sigVerified = 0;
    leaf(ELC_OP_INIT, 1, ELC_ERR_SIG);
    sigVerified = 1;
    leaf(ELC_OP_INIT, 1, ELC_ERR_TOKEN);
    signerKeyHash = kh;
    leaf(ELC_OP_INIT, 0);
    chk("initialized", 1, initialized);
    chk("sealingAuthority", kh, sealingAuthority);
    chk("enclaveIdentity", measurement, enclaveIdentity);
    leaf(ELC_OP_PGADD, 1, ELC_ERR_STATE);
    leaf(ELC_OP_KEYDRV, 0);
    foreignTcs = 1;
    leaf(ELC_OP_ENTER, 1, ELC_ERR_STATE);
    foreignTcs = 0;
    $display("test init done");
    leaf(ELC_OP_ENTER, 0);
    chk("jumpAddr", threadEntryAddr, jumpAddr);
    chk("extendedControl", featureRequestMask, extendedControl);
    chk("singleInstruction", !debugRequest, singleInstruction);
    chk("debugTrapsAllowed", debugRequest, debugTrapsAllowed);
    chk("threadBusy", 4'h1, threadBusy);
    leaf(ELC_OP_ENTER, 1, ELC_ERR_BUSY);
    {stackPtrIn, framePtrIn} = '0; // Secrets scrubbed before leaving
    leaf(ELC_OP_EXIT, 0);
    chk("returnedExitAddr", asyncExitReturnAddr, returnedExitAddr);
    chk("jumpAddr", exitTarget, jumpAddr);
    $display("test entry done");
    for (int m = 0; m < 2; m++) begin
      {longModeActive, debugRequest} = {2{m[0]}};
      leaf(ELC_OP_ENTER, 0);
      exitingEvent = 1;
      @(posedge clk) #1 exitingEvent = 0;
      wt(loadSynthetic);
      chk("eventAddr", asyncExitReturnAddr, eventAddr);
      chk("enclaveMode", 0, enclaveMode);
      leaf(ELC_OP_RESUME, 0);
      chk("jumpAddr", {m[0] ? {27'h12_3456, 5'h10} : 32'h0, 27'h65_4321, 5'h10}, jumpAddr);
      chk("debugTrapsAllowed", m[0], debugTrapsAllowed);
      chk("fpLayout64", m[0], fpLayout64);
      chk("xfeatRestoreMask", featureRequestMask, xfeatRestoreMask);
      leaf(ELC_OP_EXIT, 0);
    end
    exitingEvent = 1;
    @(posedge clk) #1 exitingEvent = 0;
    wt(outsideEvent);
    $display("test resume done");
    summarize();
  end
endmodule : elc_lifecycle_ctrl_tb_top
bind elc_lifecycle_ctrl elc_asserts u_chk (.*);

// ---- tb/elc_sw_model.sv ----
// Software-side model: frame words and caller parameters
`timescale 1ns/100ps
module elc_sw_model (
  input  wire logic [4:0] frameRdIdx,
  input  wire logic       foreignTcs,
  output logic [63:0]     frameRdData,
  output logic            threadStructOwned,
  output logic [63:0]     asyncExitReturnAddr
);
  // Index folded into each word so a wrong slot shows
  assign frameRdData = {27'h12_3456, frameRdIdx, 27'h65_4321, frameRdIdx};
  assign threadStructOwned = !foreignTcs;
  assign asyncExitReturnAddr = 64'h0000_7FFF_0000_1000;
endmodule : elc_sw_model
